// ### logic/bbc_brightness.v
// Backlight brightness control register bank with AHB-Lite slave
`timescale 1ns/1ps
`include "bbc_defs.vh"

module bbc_brightness #(
  parameter STANDBY_CYCLES = `BBC_STANDBY_CYCLES
) (
  input wire ref_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire pwmIn,
  input wire [11:0] stringEnableField,
  input wire [11:0] stringOpen,
  input wire [11:0] stringShort,
  input wire [11:0] stepSize,
  output reg [11:0] ledBrightness,
  output reg backlightOn,
  output reg lowPower,
  output reg glitchFilterEn,
  output reg boostAntiphaseEn,
  output reg nvReloadReq,
  output reg [11:0] stringEnable,
  output reg [3:0] activeStrings
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Count of enabled strings, used for output phasing
  function [3:0] popCount;
    input [11:0] v;
    integer i;
    begin
      popCount = 4'h0;
      for (i = 0; i < 12; i = i + 1) begin
        popCount = popCount + {3'b000, v[i]};
      end
    end
  endfunction

  // One bounded step of the smoother toward its target
  function [11:0] stepToward;
    input [11:0] cur;
    input [11:0] tgt;
    input [11:0] step;
    begin
      if (tgt > cur) begin
        stepToward = ((tgt - cur) > step) ? cur + step : tgt;
      end else begin
        stepToward = ((cur - tgt) > step) ? cur - step : tgt;
      end
    end
  endfunction

  // Two 12-bit factors normalised back to 12 bits
  function [11:0] scaleMul;
    input [11:0] a;
    input [11:0] b;
    reg [23:0] p;
    begin
      p = a * b;
      scaleMul = p[23:12];
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] levelUpperByte; // High brightness register
  reg [7:0] brightnessLowReg; // Low brightness register, bits 7:4 kept
  reg [7:0] controlConfig; // Configuration register
  reg controlOn; // Backlight on control bit
  reg lowWritten; // Low written since last high write
  reg [11:0] level; // Active 12-bit brightness level

  // Bus pipeline
  reg wrPend; // Write data phase pending
  reg [7:0] wrIdx; // Register index of pending write
  wire addrPhase; // Valid transfer in address phase
  wire [7:0] reqIdx; // Register index of address phase
  wire [1:0] mode; // Brightness source selection

  // PWM input path
  reg pwmMeta; // First synchroniser stage
  reg pwmSync; // Second synchroniser stage
  reg input_glitch_filter_en; // Glitch-filtered PWM
  reg [2:0] filtCnt; // Stability counter of filter
  wire pwmUse; // PWM level in use
  reg [11:0] winCnt; // Duty window counter
  reg [11:0] highCnt; // High cycles in window
  reg [11:0] duty; // Measured duty cycle
  reg winTick; // End of duty window pulse
  reg [22:0] lowCnt; // Continuous low time counter
  reg pwmLowLong; // PWM held low beyond standby time

  // String fault path
  reg [23:0] faultMeta; // First synchroniser stage
  reg [23:0] faultSync; // Second synchroniser stage

  // Turn-on tracking
  reg onPrev; // Backlight state of previous cycle
  reg powerUp; // First cycle after reset
  reg [11:0] smooth; // Smoother output
  wire nextOn; // Backlight state for next cycle
  wire [11:0] smoothTarget; // Value the smoother follows
  reg [11:0] next_brightness; // Brightness for next cycle

  assign addrPhase = hsel & htrans[1] & hready;
  assign reqIdx = haddr[9:2];
  assign mode = controlConfig[`BBC_CFG_MODE_HI:`BBC_CFG_MODE_LO];

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************

  // Zero-wait slave, read data captured in the address phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= 1'b0;
      wrIdx <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= addrPhase & hwrite;
      if (addrPhase) begin
        wrIdx <= reqIdx;
      end
      if (addrPhase && !hwrite) begin
        // Read mux, unmapped addresses read zero
        case (reqIdx)
          `BBC_IDX_CONTROL: hrdata <= {31'h0, controlOn};
          `BBC_IDX_STATUS: hrdata <= {22'h0, activeStrings, 4'h0, lowPower, backlightOn};
          `BBC_IDX_BRT_LOW: hrdata <= {24'h00_0000, brightnessLowReg[7:4], 4'h0};
          `BBC_IDX_BRT_HIGH: hrdata <= {24'h00_0000, levelUpperByte};
          `BBC_IDX_DUTY: hrdata <= {20'h0_0000, duty};
          `BBC_IDX_CONFIG: hrdata <= {24'h00_0000, controlConfig};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes in the data phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      levelUpperByte <= 8'h00;
      brightnessLowReg <= 8'h00;
      controlConfig <= `BBC_CFG_RESET;
      controlOn <= 1'b0;
      lowWritten <= 1'b0;
      level <= 12'h000;
    end else if (wrPend) begin
      case (wrIdx)
        `BBC_IDX_CONTROL: begin
          controlOn <= hwdata[0];
        end
        `BBC_IDX_BRT_LOW: begin
          // Low alone does not touch the active level
          brightnessLowReg <= hwdata[7:0] & `BBC_LOW_WMASK;
          lowWritten <= 1'b1;
        end
        `BBC_IDX_BRT_HIGH: begin
          levelUpperByte <= hwdata[7:0];
          lowWritten <= 1'b0;
          if (lowWritten) begin
            level <= {hwdata[7:0], brightnessLowReg[7:4]};
          end else begin
            level <= {hwdata[7:0], hwdata[7:4]};
          end
        end
        `BBC_IDX_CONFIG: begin
          controlConfig <= hwdata[7:0] & `BBC_CFG_WMASK;
        end
        default: begin
          controlOn <= controlOn;
        end
      endcase
    end
  end

  // ****************************************************************
  // PWM input synchroniser and glitch filter
  // ****************************************************************

  // Two-stage synchroniser, then filter on stable level
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmMeta <= 1'b0;
      pwmSync <= 1'b0;
      input_glitch_filter_en <= 1'b0;
      filtCnt <= 3'h0;
    end else begin
      pwmMeta <= pwmIn;
      pwmSync <= pwmMeta;
      if (pwmSync == input_glitch_filter_en) begin
        filtCnt <= 3'h0;
      end else if (filtCnt == `BBC_FILTER_CYCLES - 1) begin
        input_glitch_filter_en <= pwmSync;
        filtCnt <= 3'h0;
      end else begin
        filtCnt <= filtCnt + 3'h1;
      end
    end
  end

  // Filtered or raw input
  assign pwmUse = controlConfig[`BBC_CFG_FILTER] ? input_glitch_filter_en : pwmSync;

  // ****************************************************************
  // Duty measurement and standby low timer
  // ****************************************************************

  // High cycles counted over a 4095-cycle window
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      winCnt <= 12'h000;
      highCnt <= 12'h000;
      duty <= 12'h000;
      winTick <= 1'b0;
    end else begin
      winTick <= 1'b0;
      if (winCnt == `BBC_DUTY_WINDOW - 1) begin
        duty <= highCnt + {11'h000, pwmUse};
        highCnt <= 12'h000;
        winCnt <= 12'h000;
        winTick <= 1'b1;
      end else begin
        highCnt <= highCnt + {11'h000, pwmUse};
        winCnt <= winCnt + 12'h001;
      end
    end
  end

  // Continuous low time, cleared by any high level
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= 23'h00_0000;
      pwmLowLong <= 1'b0;
    end else if (pwmUse) begin
      lowCnt <= 23'h00_0000;
      pwmLowLong <= 1'b0;
    end else if (lowCnt >= STANDBY_CYCLES[22:0] - 23'h00_0001) begin
      pwmLowLong <= 1'b1;
    end else begin
      lowCnt <= lowCnt + 23'h00_0001;
    end
  end

  // ****************************************************************
  // Backlight on/off, standby and reload requests
  // ****************************************************************
  assign nextOn = controlOn & ~(controlConfig[`BBC_CFG_STANDBY] & pwmLowLong);

  // On state, power state and reload pulse
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      backlightOn <= 1'b0;
      onPrev <= 1'b0;
      lowPower <= 1'b0;
      powerUp <= 1'b1;
      nvReloadReq <= 1'b0;
      glitchFilterEn <= 1'b0;
      boostAntiphaseEn <= 1'b0;
    end else begin
      backlightOn <= nextOn;
      onPrev <= backlightOn;
      lowPower <= controlConfig[`BBC_CFG_STANDBY] & pwmLowLong
        & (mode == `BBC_MODE_DUTY);
      powerUp <= 1'b0;
      // Reread at power-up always, at turn-on when enabled
      nvReloadReq <= powerUp
        | (controlConfig[`BBC_CFG_RELOAD] & nextOn & ~backlightOn);
      glitchFilterEn <= controlConfig[`BBC_CFG_FILTER];
      boostAntiphaseEn <= controlConfig[`BBC_CFG_ANTIPHASE];
    end
  end

  // ****************************************************************
  // Smoothing and brightness source
  // ****************************************************************
  assign smoothTarget = (mode == `BBC_MODE_SMDUTY) ? duty : level;

  // Smoother restarts from 0% at each turn-on
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smooth <= 12'h000;
    end else if (backlightOn && !onPrev) begin
      smooth <= 12'h000;
    end else if (winTick) begin
      smooth <= stepToward(smooth, smoothTarget, stepSize);
    end
  end

  // Brightness formed per selected source
  always @* begin
    case (mode)
      `BBC_MODE_DUTY: next_brightness = duty;
      `BBC_MODE_REG: next_brightness = smooth;
      `BBC_MODE_SMDUTY: next_brightness = scaleMul(smooth, level);
      `BBC_MODE_SMREG: next_brightness = scaleMul(smooth, duty);
      default: next_brightness = 12'h000;
    endcase
    if (!backlightOn) begin
      next_brightness = 12'h000;
    end
  end

  // Registered brightness output
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ledBrightness <= 12'h000;
    end else begin
      ledBrightness <= next_brightness;
    end
  end

  // ****************************************************************
  // Automatic string management
  // ****************************************************************

  // Fault inputs synchronised, strings masked when auto is set
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultMeta <= 24'h00_0000;
      faultSync <= 24'h00_0000;
      stringEnable <= 12'h000;
      activeStrings <= 4'h0;
    end else begin
      faultMeta <= {stringShort, stringOpen};
      faultSync <= faultMeta;
      if (controlConfig[`BBC_CFG_AUTO]) begin
        // Faulty strings dropped, healthy ones come back
        stringEnable <= stringEnableField & ~(faultSync[11:0] | faultSync[23:12]);
        activeStrings <= popCount(stringEnableField & ~(faultSync[11:0] | faultSync[23:12]));
      end else begin
        stringEnable <= stringEnableField;
        activeStrings <= popCount(stringEnableField);
      end
    end
  end

endmodule

// ### logic/bbc_defs.vh
// Constants for the backlight brightness control register bank
// ****************************************************************
// ****************************************************************
`ifndef BBC_DEFS_VH
`define BBC_DEFS_VH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define BBC_IDX_CONTROL 8'h01
`define BBC_IDX_STATUS 8'h02
`define BBC_IDX_BRT_LOW 8'h03
`define BBC_IDX_BRT_HIGH 8'h04
`define BBC_IDX_DUTY 8'h05
`define BBC_IDX_CONFIG 8'h10

// ****************************************************************
// Config field positions
// ****************************************************************
`define BBC_CFG_STANDBY 7
`define BBC_CFG_FILTER 6
`define BBC_CFG_ANTIPHASE 5
`define BBC_CFG_RELOAD 3
`define BBC_CFG_AUTO 2
`define BBC_CFG_MODE_HI 1
`define BBC_CFG_MODE_LO 0
`define BBC_CFG_WMASK 8'hEF
`define BBC_CFG_RESET 8'h00
`define BBC_LOW_WMASK 8'hF0

// ****************************************************************
// Brightness source modes
// ****************************************************************
`define BBC_MODE_DUTY 2'b00
`define BBC_MODE_REG 2'b01
`define BBC_MODE_SMDUTY 2'b10
`define BBC_MODE_SMREG 2'b11

// ****************************************************************
// Timing: figures and derived cycle counts at 100 MHz
// ****************************************************************
`define BBC_CLK_MHZ 100
`define BBC_FILTER_NS 50
`define BBC_FILTER_CYCLES ((`BBC_FILTER_NS * `BBC_CLK_MHZ + 999) / 1000)
`define BBC_STANDBY_MS 50
`define BBC_STANDBY_CYCLES (`BBC_STANDBY_MS * 1000 * `BBC_CLK_MHZ)
`define BBC_DUTY_WINDOW 4095

`endif

// ### tb/bbc_host_pwm.sv
// Host model that drives the PWM input pin
`timescale 1ns/1ps
module bbc_host_pwm (
  input wire ref_clk,
  input wire [1:0] pattern,
  output reg pwmIn
);
  reg [3:0] phase = 4'h0; // Free running pulse phase
  initial pwmIn = 1'b0;
  // 0 low, 1 steady high, 2 three-cycle glitches every 16 cycles
  always @(posedge ref_clk) begin
    phase <= phase + 4'h1;
    pwmIn <= (pattern == 2'b01) || (pattern == 2'b10 && phase < 4'h3);
  end
endmodule

// ### tb/bbc_brightness_checker.sv
// Port checker for the brightness control register bank
`timescale 1ns/1ps
module bbc_brightness_checker #(
  parameter STANDBY_CYCLES = 200
) (
  input wire ref_clk,
  input wire rst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [11:0] stringEnableField,
  input wire [11:0] ledBrightness,
  input wire backlightOn,
  input wire lowPower,
  input wire nvReloadReq,
  input wire [11:0] stringEnable,
  input wire [3:0] activeStrings
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Backlight off for two samples in a row
  sequence s_dark;
    !backlightOn ##1 !backlightOn;
  endsequence
  // Transfer taken by the slave
  sequence s_take;
    hsel && htrans[1] && hready;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  a_zero_wait: assert property (s_take |=> hreadyout) else $error("wait state");
  a_upper_zero: assert property (hrdata[31:12] == 20'h0_0000) else $error("upper set");
  a_reload_pulse: assert property (nvReloadReq |=> !nvReloadReq) else $error("long reload");
  a_dark_level: assert property (s_dark |-> ledBrightness == 12'h000) else $error("lit");
  a_sleep_off: assert property (lowPower |-> !backlightOn) else $error("sleep on");
  a_string_count: assert property ($stable(stringEnable)[*2] |->
    activeStrings == 4'($countones(stringEnable))) else $error("bad count");
  a_field_subset: assert property ($stable(stringEnableField)[*3] |->
    (stringEnable & ~stringEnableField) == 12'h000) else $error("extra string");
endmodule

bind bbc_brightness bbc_brightness_checker #(.STANDBY_CYCLES(STANDBY_CYCLES)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .stringEnableField(stringEnableField), .ledBrightness(ledBrightness),
  .backlightOn(backlightOn), .lowPower(lowPower), .nvReloadReq(nvReloadReq),
  .stringEnable(stringEnable), .activeStrings(activeStrings)
);

// ### tb/testbench.sv
// Self-checking testbench for the brightness control register bank
`timescale 1ns/1ps
`include "bbc_defs.vh"
module testbench;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0000_0000;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0000_0000;
  reg [1:0] pattern = 2'b00; // Host PWM pattern
  reg [11:0] stringEnableField = 12'hFFF;
  reg [11:0] stringOpen = 12'h000;
  reg [11:0] stringShort = 12'h000;
  reg [11:0] stepSize = 12'hFFF; // Full step: ramp lands in one window
  wire [31:0] hrdata;
  wire hreadyout, hresp, pwmIn, backlightOn, lowPower;
  wire glitchFilterEn, boostAntiphaseEn, nvReloadReq;
  wire [11:0] ledBrightness, stringEnable;
  wire [3:0] activeStrings;
  reg [31:0] rd; // Last read data
  integer fail_count = 0;
  integer n_checks = 0;
  integer pulses = 0; // Reload pulses seen

  always #5 ref_clk = ~ref_clk;
  // Count reload requests
  always @(posedge ref_clk) begin
    if (nvReloadReq === 1'b1) pulses <= pulses + 1;
  end

  bbc_brightness #(.STANDBY_CYCLES(200)) i_bbc_brightness (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwmIn(pwmIn),
    .stringEnableField(stringEnableField), .stringOpen(stringOpen),
    .stringShort(stringShort), .stepSize(stepSize), .ledBrightness(ledBrightness),
    .backlightOn(backlightOn), .lowPower(lowPower), .glitchFilterEn(glitchFilterEn),
    .boostAntiphaseEn(boostAntiphaseEn), .nvReloadReq(nvReloadReq),
    .stringEnable(stringEnable), .activeStrings(activeStrings));
  bbc_host_pwm i_bbc_host_pwm (.ref_clk(ref_clk), .pattern(pattern), .pwmIn(pwmIn));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One AHB single transfer, read data lands in rd
  task automatic xfer(input wr, input [7:0] idx, input [7:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'b00};
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
    end
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Optional low write, high write, then one smoothing window
  task automatic lvl(input doLow, input [7:0] lo, input [7:0] hi, input [11:0] exp);
    begin
      if (doLow) xfer(1'b1, `BBC_IDX_BRT_LOW, lo);
      xfer(1'b1, `BBC_IDX_BRT_HIGH, hi);
      cyc(4110);
      chk(ledBrightness, exp);
    end
  endtask
  task results;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // Watchdog
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    results;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    // Power-up pulse is counted at the second edge, visible after the third
    cyc(3);
    chk(pulses, 1);
    xfer(1'b0, `BBC_IDX_CONFIG, 8'h00);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'hFF);
    xfer(1'b0, `BBC_IDX_CONFIG, 8'h00);
    chk(rd, 32'h0000_00EF);
    chk(glitchFilterEn, 1'b1);
    chk(boostAntiphaseEn, 1'b1);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h01);
    xfer(1'b1, `BBC_IDX_BRT_HIGH, 8'hFF);
    xfer(1'b1, `BBC_IDX_CONTROL, 8'h01);
    cyc(2);
    chk(ledBrightness, 12'h000);
    chk(boostAntiphaseEn, 1'b0);
    lvl(1'b1, 8'h95, 8'hFC, 12'hFC9);
    lvl(1'b1, 8'h10, 8'hDC, 12'hDC1);
    lvl(1'b0, 8'h00, 8'h8C, 12'h8C8);
    lvl(1'b0, 8'h00, 8'h0C, 12'h0C0);
    lvl(1'b0, 8'h00, 8'h00, 12'h000);
    lvl(1'b0, 8'h00, 8'hFF, 12'hFFF);
    xfer(1'b1, `BBC_IDX_BRT_LOW, 8'h95);
    cyc(4110);
    chk(ledBrightness, 12'hFFF);
    xfer(1'b0, `BBC_IDX_BRT_LOW, 8'h00);
    chk(rd, 32'h0000_0090);
    xfer(1'b0, `BBC_IDX_BRT_HIGH, 8'h00);
    chk(rd, 32'h0000_00FF);
    xfer(1'b0, 8'h3F, 8'h00);
    chk(rd, 32'h0000_0000);
    chk(pulses, 1);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h09);
    xfer(1'b1, `BBC_IDX_CONTROL, 8'h00);
    xfer(1'b1, `BBC_IDX_CONTROL, 8'h01);
    cyc(4);
    chk(pulses, 2);
    chk(backlightOn, 1'b1);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h80);
    cyc(300);
    chk(backlightOn, 1'b0);
    chk(lowPower, 1'b1);
    xfer(1'b0, `BBC_IDX_STATUS, 8'h00);
    chk(rd, 32'h0000_0302);
    pattern <= 2'b01;
    cyc(20);
    chk(backlightOn, 1'b1);
    chk(lowPower, 1'b0);
    cyc(8200);
    chk(ledBrightness, 12'hFFF);
    xfer(1'b0, `BBC_IDX_DUTY, 8'h00);
    chk(rd, 32'h0000_0FFF);
    xfer(1'b1, `BBC_IDX_BRT_LOW, 8'h00);
    xfer(1'b1, `BBC_IDX_BRT_HIGH, 8'h80);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h82);
    cyc(8200);
    chk(ledBrightness, 12'h7FF);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h83);
    cyc(8200);
    chk(ledBrightness, 12'h7FF);
    pattern <= 2'b10;
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h40);
    cyc(8200);
    xfer(1'b0, `BBC_IDX_DUTY, 8'h00);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h00);
    cyc(8200);
    xfer(1'b0, `BBC_IDX_DUTY, 8'h00);
    // Three high cycles in sixteen over a 4095-cycle window: 767 or 768
    chk(rd == 32'h0000_02FF || rd == 32'h0000_0300, 1'b1);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h04);
    stringOpen <= 12'h005;
    stringShort <= 12'h100;
    cyc(6);
    chk(stringEnable, 12'hEFA);
    chk(activeStrings, 4'h9);
    stringOpen <= 12'h000;
    stringShort <= 12'h000;
    cyc(6);
    chk(stringEnable, 12'hFFF);
    xfer(1'b1, `BBC_IDX_CONFIG, 8'h00);
    stringOpen <= 12'h005;
    cyc(6);
    chk(stringEnable, 12'hFFF);
    results;
  end
endmodule
